/* rsfm_map.vh */
`ifndef RSFM_MAP_VH
`define RSFM_MAP_VH

// Register offsets on the plain register port.
`define RSFM_ADDR_W 5
`define RSFM_OFS_LIVE 5'h00
`define RSFM_OFS_STICKY 5'h01
`define RSFM_OFS_SEL 5'h02
`define RSFM_OFS_IE 5'h03
`define RSFM_OFS_HIZ 5'h04
`define RSFM_OFS_CFG 5'h05
`define RSFM_OFS_FATAL 5'h06
`define RSFM_OFS_EVENT 5'h07
`define RSFM_OFS_TARGET 5'h08
`define RSFM_OFS_FLOOR 5'h09
`define RSFM_OFS_CEIL 5'h0a
`define RSFM_OFS_AMP 5'h0b
`define RSFM_OFS_OFS_LIM 5'h0c
`define RSFM_OFS_BAL_LIM 5'h0d
`define RSFM_OFS_PH_LIM 5'h0e
`define RSFM_OFS_ZPH_LIM 5'h0f
`define RSFM_OFS_CMD 5'h10
`define RSFM_OFS_STATUS 5'h11

// Field positions.
`define RSFM_COND_AMP 5
`define RSFM_COND_RES 7
`define RSFM_CFG_FILT_HI 2
`define RSFM_CFG_FILT_LO 0
`define RSFM_CFG_ENC 3
`define RSFM_CFG_ENZ 4
`define RSFM_EVT_ROLL 0
`define RSFM_EVT_CAP 1
`define RSFM_STAT_IRQ 0
`define RSFM_STAT_PINMODE 1
`define RSFM_TRISTATE_ENABLE_MASK 2

// Reset values.
`define RSFM_RST_TARGET 8'h96
`define RSFM_RST_FLOOR 8'h87
`define RSFM_RST_CEIL 8'ha5
`define RSFM_RST_LIM 8'hff
`define RSFM_RST_MASK 8'h00

// Pin configuration mode fixed masks.
`define RSFM_PIN_SEL 8'h00
`define RSFM_PIN_IE 8'h26
`define RSFM_PIN_HIZ 8'h00

// Commands.
`define RSFM_CMD_NVM_STORE 8'h11
`define RSFM_CMD_CAL_SC 8'h21
`define RSFM_CMD_CAL_ALL 8'h23
`define RSFM_CMD_RESTART 8'h01

// Timing: filter step of one microsecond at a 20 ns clock.
`define RSFM_CLK_PERIOD_NS 20
`define RSFM_FILTER_STEP_NS 1000
`define RSFM_FILTER_STEP_CYC (`RSFM_FILTER_STEP_NS / `RSFM_CLK_PERIOD_NS)

`endif

/* rsfm_debounce.v */
`timescale 1ns/1ns
`default_nettype none

module rsfm_debounce #(
    parameter CNT_W = 12
) (
    // Clock and reset.
    input wire clk_i,
    input wire rst_i,
    // Raw condition and programmed hold time in cycles.
    input wire cond_i,
    input wire [CNT_W-1:0] hold_i,
    // Filtered flag.
    output reg flag_o
);

    reg [CNT_W-1:0] cnt_reg;

    // The flag rises only after an unbroken run; any gap restarts the count.
    always @(posedge clk_i)
    begin
        if (rst_i || !cond_i)
        begin
            cnt_reg <= {CNT_W{1'b0}};
            flag_o <= 1'b0;
        end
        else if (cnt_reg >= hold_i)
        begin
            flag_o <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // rsfm_debounce

`default_nettype wire

/* rsfm_isqrt.v */
`timescale 1ns/1ns
`default_nettype none

module rsfm_isqrt (
    // Clock and reset.
    input wire clk_i,
    input wire rst_i,
    // Request.
    input wire start_i,
    input wire [15:0] value_i,
    // Result.
    output wire busy_o,
    output reg [7:0] root_o,
    output reg done_o
);

    reg [15:0] value_reg;
    reg [7:0] work_reg;
    reg [7:0] bit_reg;
    wire [7:0] trial;
    wire [15:0] trial_sq;

    assign trial = work_reg | bit_reg;
    assign trial_sq = trial * trial;
    assign busy_o = (bit_reg != 8'h00);

    // One result bit per cycle trades latency for a single small multiplier.
    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        if (rst_i)
        begin
            value_reg <= 16'h0000;
            work_reg <= 8'h00;
            bit_reg <= 8'h00;
            root_o <= 8'h00;
        end
        else if (!busy_o)
        begin
            if (start_i)
            begin
                value_reg <= value_i;
                work_reg <= 8'h00;
                bit_reg <= 8'h80;
            end
        end
        else
        begin
            if (trial_sq <= value_reg)
            begin
                work_reg <= trial;
            end
            bit_reg <= {1'b0, bit_reg[7:1]};
            if (bit_reg == 8'h01)
            begin
                root_o <= (trial_sq <= value_reg) ? trial : work_reg;
                done_o <= 1'b1;
            end
        end
    end

endmodule // rsfm_isqrt

`default_nettype wire

/* rsfm_monitor.v */
`timescale 1ns/1ns
`default_nettype none
`include "rsfm_map.vh"

module rsfm_monitor #(
    parameter FILT_CNT_W = 12
) (
    // Clock and reset.
    input wire CLK_SYS_I,
    input wire SYS_RST_I,
    // Register port.
    input wire [`RSFM_ADDR_W-1:0] REG_ADDR_I,
    input wire [7:0] REG_WDATA_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    output reg [7:0] REG_RDATA_O,
    // Pins from outside the clock domain.
    input wire PIN_MODE_I,
    input wire CALIBRATE_PIN_N_I,
    // Raw conditions and events from the device core.
    input wire [7:0] COND_RAW_I,
    input wire [2:0] FATAL_RAW_I,
    input wire ROLLOVER_I,
    input wire CAPTURE_I,
    // Signal path samples and residues, two's complement.
    input wire [7:0] SIN_I,
    input wire [7:0] COS_I,
    input wire [7:0] SINE_OFFSET_ERROR_I,
    input wire [7:0] COSINE_OFFSET_ERROR_I,
    input wire [7:0] BALANCE_ERROR_I,
    input wire [7:0] QUADRATURE_PHASE_ERROR_I,
    input wire [7:0] INDEX_PHASE_ERROR_I,
    // Interrupt, tristate and status.
    output wire INTERRUPT_OUT_N_O,
    output wire IRQ_O,
    output wire ABZ_HIZ_O,
    output wire [7:0] STATUS_BYTE_O,
    // Calibration and storage requests, and the amplitude target.
    output reg CAL_START_O,
    output reg CAL_ALL_O,
    output reg NVM_STORE_O,
    output wire [7:0] AMPLITUDE_TARGET_O
);

    // Magnitude of a two's complement byte, 0x80 saturates to 0x80.
    function [7:0] mag;
        input [7:0] v;
        begin
            mag = v[7] ? (~v + 8'h01) : v;
        end
    endfunction

    // Synchroniser chains for the two pins.
    reg [1:0] sync1_reg;
    reg [1:0] sync2_reg;
    reg [1:0] sync3_reg;
    reg [1:0] pin_val_reg;
    wire pin_mode;
    wire cal_pin_n;

    // Registers.
    reg [7:0] sticky_reg;
    reg [7:0] sel_reg;
    reg [7:0] ie_reg;
    reg [7:0] hiz_reg;
    reg [4:0] cfg_reg;
    reg [2:0] fatal_reg;
    reg [1:0] event_reg;
    reg [7:0] target_reg;
    reg [7:0] floor_reg;
    reg [7:0] ceil_reg;
    reg [7:0] ofs_lim_reg;
    reg [7:0] bal_lim_reg;
    reg [7:0] ph_lim_reg;
    reg [7:0] zph_lim_reg;
    reg cal_pin_old_reg;
    reg [7:0] rdata_next;

    // Condition path.
    wire [7:0] cond_in;
    wire [7:0] live;
    wire [7:0] eff_sel;
    wire [7:0] eff_ie;
    wire [7:0] eff_hiz;
    wire [7:0] chosen;
    wire [FILT_CNT_W-1:0] hold_cyc;
    wire amp_fault;
    wire res_fault;
    wire wr_sticky;
    wire wr_event;
    wire wr_cmd;
    wire restart;

    // Amplitude monitor.
    wire [15:0] sin_sq;
    wire [15:0] cos_sq;
    wire [15:0] amp_sq;
    wire [7:0] amp;
    wire sqrt_busy;
    wire [10:0] tgt3;
    wire [10:0] tgt6;
    wire [8:0] pin_floor;
    wire [8:0] pin_ceil;
    wire [10:0] floor_full;
    wire [10:0] ceil_full;

    // Three flops per pin; a change counts when stages two and three agree.
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            sync1_reg <= 2'h2;
            sync2_reg <= 2'h2;
            sync3_reg <= 2'h2;
            pin_val_reg <= 2'h2;
        end
        else
        begin
            sync1_reg <= {CALIBRATE_PIN_N_I, PIN_MODE_I};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg[0] == sync3_reg[0])
            begin
                pin_val_reg[0] <= sync3_reg[0];
            end
            if (sync2_reg[1] == sync3_reg[1])
            begin
                pin_val_reg[1] <= sync3_reg[1];
            end
        end
    end

    assign pin_mode = pin_val_reg[0];
    assign cal_pin_n = pin_val_reg[1];

    // Sum of squares feeds the root engine, restarted as soon as it idles.
    assign sin_sq = $signed(SIN_I) * $signed(SIN_I);
    assign cos_sq = $signed(COS_I) * $signed(COS_I);
    assign amp_sq = sin_sq + cos_sq;

    rsfm_isqrt u_isqrt (
        .clk_i(CLK_SYS_I),
        .rst_i(SYS_RST_I),
        .start_i(1'b1),
        .value_i(amp_sq),
        .busy_o(sqrt_busy),
        .root_o(amp),
        .done_o()
    );

    // Pin mode limits at 60 and 120 percent of the calibrated target.
    assign tgt3 = {3'h0, target_reg} * 11'h003;
    assign tgt6 = {3'h0, target_reg} * 11'h006;
    assign floor_full = tgt3 / 11'h005;
    assign ceil_full = tgt6 / 11'h005;
    // Dividing the full products keeps a large target from wrapping.
    assign pin_floor = floor_full[8:0];
    assign pin_ceil = ceil_full[8:0];

    // Amplitude fault uses fixed ratios in pin mode, register limits otherwise.
    assign amp_fault = pin_mode
        ? (({1'b0, amp} < pin_floor) || ({1'b0, amp} > pin_ceil))
        : ((amp < floor_reg) || (amp > ceil_reg));

    // Residue magnitudes against their limits; both offsets share one limit.
    assign res_fault = (mag(SINE_OFFSET_ERROR_I) > ofs_lim_reg)
                    || (mag(COSINE_OFFSET_ERROR_I) > ofs_lim_reg)
                    || (mag(BALANCE_ERROR_I) > bal_lim_reg)
                    || (mag(QUADRATURE_PHASE_ERROR_I) > ph_lim_reg)
                    || (mag(INDEX_PHASE_ERROR_I) > zph_lim_reg);

    // Internal monitors replace the raw bits 5 and 7.
    assign cond_in = {res_fault, COND_RAW_I[6], amp_fault, COND_RAW_I[4:0]};

    // The step count is cut to the counter width before it is scaled.
    localparam [31:0] FILT_STEP_FULL = `RSFM_FILTER_STEP_CYC;
    localparam [FILT_CNT_W-1:0] FILT_STEP = FILT_STEP_FULL[FILT_CNT_W-1:0];
    assign hold_cyc = cfg_reg[`RSFM_CFG_FILT_HI:`RSFM_CFG_FILT_LO]
                    * FILT_STEP;

    // One debounce filter per condition.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_filt
            rsfm_debounce #(
                .CNT_W(FILT_CNT_W)
            ) u_filt (
                .clk_i(CLK_SYS_I),
                .rst_i(SYS_RST_I),
                .cond_i(cond_in[gi]),
                .hold_i(hold_cyc),
                .flag_o(live[gi])
            );
        end
    endgenerate

    // Pin mode overrides the software masks.
    assign eff_sel = pin_mode ? `RSFM_PIN_SEL : sel_reg;
    assign eff_ie = pin_mode ? `RSFM_PIN_IE : ie_reg;
    assign eff_hiz = pin_mode ? `RSFM_PIN_HIZ : hiz_reg;
    assign chosen = (eff_sel & sticky_reg) | (~eff_sel & live);

    // Fatal faults always win; events count only while pending.
    assign IRQ_O = (|(chosen & eff_ie)) || (|fatal_reg)
                || (|event_reg);
    assign INTERRUPT_OUT_N_O = ~IRQ_O;
    assign ABZ_HIZ_O = (|(chosen & eff_hiz)) || (|fatal_reg);
    assign STATUS_BYTE_O = {5'h00, ABZ_HIZ_O, pin_mode, IRQ_O};
    assign AMPLITUDE_TARGET_O = target_reg;

    assign wr_sticky = REG_WR_I && (REG_ADDR_I == `RSFM_OFS_STICKY);
    assign wr_event = REG_WR_I && (REG_ADDR_I == `RSFM_OFS_EVENT);
    assign wr_cmd = REG_WR_I && (REG_ADDR_I == `RSFM_OFS_CMD);
    assign restart = wr_cmd && (REG_WDATA_I == `RSFM_CMD_RESTART);

    // Flags: a new set wins over a clear in the same cycle.
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            sticky_reg <= 8'h00;
            fatal_reg <= 3'h0;
            event_reg <= 2'h0;
        end
        else
        begin
            sticky_reg <= (sticky_reg & ~(wr_sticky ? REG_WDATA_I : 8'h00))
                        | live;
            // Only reset or restart releases a fatal flag.
            fatal_reg <= (restart ? 3'h0 : fatal_reg) | FATAL_RAW_I;
            event_reg[`RSFM_EVT_ROLL] <= (event_reg[`RSFM_EVT_ROLL]
                && !(wr_event && REG_WDATA_I[`RSFM_EVT_ROLL]))
                || (ROLLOVER_I && cfg_reg[`RSFM_CFG_ENC]);
            event_reg[`RSFM_EVT_CAP] <= (event_reg[`RSFM_EVT_CAP]
                && !(wr_event && REG_WDATA_I[`RSFM_EVT_CAP]))
                || (CAPTURE_I && cfg_reg[`RSFM_CFG_ENZ]);
        end
    end

    // Configuration registers written by software.
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            sel_reg <= `RSFM_RST_MASK;
            ie_reg <= `RSFM_RST_MASK;
            hiz_reg <= `RSFM_RST_MASK;
            cfg_reg <= 5'h00;
            target_reg <= `RSFM_RST_TARGET;
            floor_reg <= `RSFM_RST_FLOOR;
            ceil_reg <= `RSFM_RST_CEIL;
            ofs_lim_reg <= `RSFM_RST_LIM;
            bal_lim_reg <= `RSFM_RST_LIM;
            ph_lim_reg <= `RSFM_RST_LIM;
            zph_lim_reg <= `RSFM_RST_LIM;
        end
        else if (REG_WR_I)
        begin
            case (REG_ADDR_I)
                `RSFM_OFS_SEL: sel_reg <= REG_WDATA_I;
                `RSFM_OFS_IE: ie_reg <= REG_WDATA_I;
                `RSFM_OFS_HIZ: hiz_reg <= REG_WDATA_I;
                `RSFM_OFS_CFG: cfg_reg <= REG_WDATA_I[4:0];
                `RSFM_OFS_TARGET: target_reg <= REG_WDATA_I;
                `RSFM_OFS_FLOOR: floor_reg <= REG_WDATA_I;
                `RSFM_OFS_CEIL: ceil_reg <= REG_WDATA_I;
                `RSFM_OFS_OFS_LIM: ofs_lim_reg <= REG_WDATA_I;
                `RSFM_OFS_BAL_LIM: bal_lim_reg <= REG_WDATA_I;
                `RSFM_OFS_PH_LIM: ph_lim_reg <= REG_WDATA_I;
                `RSFM_OFS_ZPH_LIM: zph_lim_reg <= REG_WDATA_I;
                default: ;
            endcase
        end
    end

    // Command and calibrate pin produce one-cycle request pulses.
    // Storage itself lives elsewhere; this block only raises the request.
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            cal_pin_old_reg <= 1'b1;
            CAL_START_O <= 1'b0;
            CAL_ALL_O <= 1'b0;
            NVM_STORE_O <= 1'b0;
        end
        else
        begin
            cal_pin_old_reg <= cal_pin_n;
            CAL_START_O <= (cal_pin_old_reg && !cal_pin_n)
                || (wr_cmd && (REG_WDATA_I == `RSFM_CMD_CAL_SC))
                || (wr_cmd && (REG_WDATA_I == `RSFM_CMD_CAL_ALL));
            CAL_ALL_O <= (cal_pin_old_reg && !cal_pin_n)
                || (wr_cmd && (REG_WDATA_I == `RSFM_CMD_CAL_ALL));
            NVM_STORE_O <= wr_cmd
                && (REG_WDATA_I == `RSFM_CMD_NVM_STORE);
        end
    end

    // Read mux; unmapped and write-only offsets read as zero.
    always @*
    begin
        rdata_next = 8'h00;
        case (REG_ADDR_I)
            `RSFM_OFS_LIVE: rdata_next = live;
            `RSFM_OFS_STICKY: rdata_next = sticky_reg;
            `RSFM_OFS_SEL: rdata_next = sel_reg;
            `RSFM_OFS_IE: rdata_next = ie_reg;
            `RSFM_OFS_HIZ: rdata_next = hiz_reg;
            `RSFM_OFS_CFG: rdata_next = {3'h0, cfg_reg};
            `RSFM_OFS_FATAL: rdata_next = {5'h00, fatal_reg};
            `RSFM_OFS_EVENT: rdata_next = {6'h00, event_reg};
            `RSFM_OFS_TARGET: rdata_next = target_reg;
            `RSFM_OFS_FLOOR: rdata_next = floor_reg;
            `RSFM_OFS_CEIL: rdata_next = ceil_reg;
            `RSFM_OFS_AMP: rdata_next = amp;
            `RSFM_OFS_OFS_LIM: rdata_next = ofs_lim_reg;
            `RSFM_OFS_BAL_LIM: rdata_next = bal_lim_reg;
            `RSFM_OFS_PH_LIM: rdata_next = ph_lim_reg;
            `RSFM_OFS_ZPH_LIM: rdata_next = zph_lim_reg;
            `RSFM_OFS_STATUS: rdata_next = STATUS_BYTE_O;
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stands for exactly the cycle after the strobe.
    always @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            REG_RDATA_O <= 8'h00;
        end
        else
        begin
            REG_RDATA_O <= REG_RD_I ? rdata_next : 8'h00;
        end
    end

endmodule // rsfm_monitor

`default_nettype wire

/* rsfm_monitor_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "rsfm_map.vh"

module rsfm_monitor_checker #(
    parameter FILT_CNT_W = 12
) (
    // Clock and reset.
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // Register port.
    input wire logic [`RSFM_ADDR_W-1:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    // Mode strap and fatal sources.
    input wire logic PIN_MODE_I,
    input wire logic [2:0] FATAL_RAW_I,
    // Interrupt, tristate, status and request pulses.
    input wire logic INTERRUPT_OUT_N_O,
    input wire logic IRQ_O,
    input wire logic ABZ_HIZ_O,
    input wire logic [7:0] STATUS_BYTE_O,
    input wire logic CAL_START_O,
    input wire logic CAL_ALL_O,
    input wire logic NVM_STORE_O
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (SYS_RST_I);

    // Writes to the command offset, decoded once for several checks.
    logic cmd_wr;
    assign cmd_wr = REG_WR_I && (REG_ADDR_I == `RSFM_OFS_CMD);

    // Shadow of the fatal flags. It clears at the restart write edge, so a
    // design that clears one edge later trips a_pin_hiz_fatal in pin mode, though not a_fatal_forces_all.
    logic fatal_seen_reg;
    logic fatal_seen_next;
    always_comb
    begin
        fatal_seen_next = fatal_seen_reg;
        if (cmd_wr && REG_WDATA_I == `RSFM_CMD_RESTART)
            fatal_seen_next = 1'b0;
        if (FATAL_RAW_I != 3'h0)
            fatal_seen_next = 1'b1;
        if (SYS_RST_I)
            fatal_seen_next = 1'b0;
    end
    always_ff @(posedge CLK_SYS_I)
        fatal_seen_reg <= fatal_seen_next;

    a_irq_pin_inverse: assert property (INTERRUPT_OUT_N_O == !IRQ_O)
        else $error("interrupt pin is not the inverse of pending");
    a_status_irq_bit: assert property (STATUS_BYTE_O[0] == IRQ_O)
        else $error("status byte irq bit differs from pending");
    a_status_hiz_bit: assert property (STATUS_BYTE_O[2] == ABZ_HIZ_O
        && STATUS_BYTE_O[7:3] == 5'h00)
        else $error("status byte tristate or spare bits wrong");
    a_fatal_forces_all: assert property (fatal_seen_reg |->
        IRQ_O && ABZ_HIZ_O)
        else $error("fatal flag without interrupt and tristate");
    a_pin_hiz_fatal: assert property (PIN_MODE_I &&
        $past(PIN_MODE_I, 8) && !fatal_seen_reg |-> !ABZ_HIZ_O)
        else $error("tristate in pin mode without fatal fault");
    a_cal_sc_pulse: assert property (cmd_wr &&
        REG_WDATA_I == `RSFM_CMD_CAL_SC |=>
        (CAL_START_O && !CAL_ALL_O) ##1 !CAL_START_O)
        else $error("sine cosine calibration pulse wrong");
    a_cal_all_pulse: assert property (cmd_wr &&
        REG_WDATA_I == `RSFM_CMD_CAL_ALL |=>
        (CAL_START_O && CAL_ALL_O) ##1 !(CAL_START_O || CAL_ALL_O))
        else $error("all channel calibration pulse wrong");
    a_nvm_store_pulse: assert property (cmd_wr &&
        REG_WDATA_I == `RSFM_CMD_NVM_STORE |=>
        (NVM_STORE_O && !CAL_START_O) ##1 !NVM_STORE_O)
        else $error("storage request pulse wrong");
    a_rdata_idle_zero: assert property (!$past(REG_RD_I) |->
        REG_RDATA_O == 8'h00)
        else $error("read data not zero outside read answer");
endmodule // rsfm_monitor_checker

bind rsfm_monitor rsfm_monitor_checker #(
    .FILT_CNT_W(FILT_CNT_W)
) u_rsfm_monitor_checker (
    .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .PIN_MODE_I(PIN_MODE_I), .FATAL_RAW_I(FATAL_RAW_I),
    .INTERRUPT_OUT_N_O(INTERRUPT_OUT_N_O), .IRQ_O(IRQ_O),
    .ABZ_HIZ_O(ABZ_HIZ_O), .STATUS_BYTE_O(STATUS_BYTE_O),
    .CAL_START_O(CAL_START_O), .CAL_ALL_O(CAL_ALL_O),
    .NVM_STORE_O(NVM_STORE_O)
);

`default_nettype wire

/* rsfm_fault_led.sv */
`timescale 1ns/1ns
`default_nettype none

module rsfm_fault_led (
    // Active-low drive from the interrupt pin.
    input wire logic irq_n_i,
    // Light state seen by an operator.
    output logic lit_o
);
    // The lamp sinks current only on a firm low; an unknown leaves it dark.
    assign lit_o = (irq_n_i === 1'b0);
endmodule // rsfm_fault_led

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
    // Register port drive.
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    // Pins, raw conditions, events and signal path samples.
    logic pin_mode = 1'b0;
    logic cal_n = 1'b1;
    logic [7:0] cond = 8'h00;
    logic [2:0] fatal = 3'h0;
    logic [1:0] ev = 2'h0;
    logic [7:0] sc = 8'h6a;
    logic [7:0] res [0:4] = '{default: 8'h00};
    wire [7:0] rdata;
    wire [7:0] status;
    wire [7:0] target;
    wire irq_n;
    wire irq;
    wire hiz;
    wire cal_st;
    wire cal_all;
    wire led;
    integer mismatches = 0;
    integer cmp_count = 0;
    integer i;
    logic hit;
    logic [7:0] lim;

    // Free-running system clock.
    always #10 clk_sys = ~clk_sys;

    rsfm_monitor #(
        .FILT_CNT_W(12)
    ) u_rsfm_monitor (
        .CLK_SYS_I(clk_sys), .SYS_RST_I(sys_rst), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .PIN_MODE_I(pin_mode),
        .CALIBRATE_PIN_N_I(cal_n), .COND_RAW_I(cond), .FATAL_RAW_I(fatal),
        .ROLLOVER_I(ev[0]), .CAPTURE_I(ev[1]), .SIN_I(sc), .COS_I(sc),
        .SINE_OFFSET_ERROR_I(res[0]), .COSINE_OFFSET_ERROR_I(res[1]),
        .BALANCE_ERROR_I(res[2]), .QUADRATURE_PHASE_ERROR_I(res[3]),
        .INDEX_PHASE_ERROR_I(res[4]), .INTERRUPT_OUT_N_O(irq_n),
        .IRQ_O(irq), .ABZ_HIZ_O(hiz), .STATUS_BYTE_O(status),
        .CAL_START_O(cal_st), .CAL_ALL_O(cal_all), .NVM_STORE_O(),
        .AMPLITUDE_TARGET_O(target)
    );

    rsfm_fault_led u_rsfm_fault_led (
        .irq_n_i(irq_n),
        .lit_o(led)
    );

    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task wt(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One-cycle write strobe, released at the following edge.
    task wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // Read data are looked at only in the cycle after the strobe.
    task rd_chk(input string n, input logic [4:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        chk(n, e, rdata);
    endtask

    task out_chk(input logic e_hiz, input logic e_irq);
        #1;
        chk("hiz_irq", {6'h00, e_hiz, e_irq}, {6'h00, hiz, irq});
    endtask

    initial
    begin
        wt(2);
        sys_rst <= 1'b0;
        rd_chk("target", 5'h08, 8'h96);
        rd_chk("floor", 5'h09, 8'h87);
        rd_chk("ceiling", 5'h0a, 8'ha5);
        for (i = 0; i < 4; i++)
            rd_chk("limit", 5'h0c + i[4:0], 8'hff);
        rd_chk("select", 5'h02, 8'h00);
        rd_chk("irq_mask", 5'h03, 8'h00);
        rd_chk("hiz_mask", 5'h04, 8'h00);
        wr_reg(5'h00, 8'hff);
        rd_chk("live_ro", 5'h00, 8'h00);
        rd_chk("unmapped", 5'h1f, 8'h00);
        chk("target_out", 8'h96, target);
        // The amplitude reads zero until the first root is ready.
        wr_reg(5'h01, 8'hff);
        rd_chk("sticky_boot", 5'h01, 8'h00);
        $display("test reset ended");
        // Filter of one step: 51 cycles of steady condition are needed.
        wr_reg(5'h05, 8'h01);
        cond <= 8'h01;
        wt(40);
        rd_chk("live_early", 5'h00, 8'h00);
        wt(20);
        rd_chk("live_held", 5'h00, 8'h01);
        cond <= 8'h00;
        wt(3);
        rd_chk("live_drop", 5'h00, 8'h00);
        rd_chk("sticky_kept", 5'h01, 8'h01);
        wr_reg(5'h01, 8'h02);
        rd_chk("sticky_other", 5'h01, 8'h01);
        wr_reg(5'h03, 8'h01);
        out_chk(1'b0, 1'b0);
        wr_reg(5'h02, 8'h01);
        out_chk(1'b0, 1'b1);
        wr_reg(5'h04, 8'h01);
        out_chk(1'b1, 1'b1);
        wr_reg(5'h03, 8'h00);
        out_chk(1'b1, 1'b0);
        wr_reg(5'h01, 8'h01);
        out_chk(1'b0, 1'b0);
        rd_chk("sticky_clr", 5'h01, 8'h00);
        wr_reg(5'h04, 8'h00);
        wr_reg(5'h05, 8'h00);
        $display("test flags ended");
        // Amplitude 134 lies below the floor of 135, amplitude 135 does not.
        sc <= 8'h5f;
        wt(30);
        rd_chk("amp_low", 5'h00, 8'h20);
        sc <= 8'h60;
        wt(30);
        rd_chk("amp_edge", 5'h00, 8'h00);
        rd_chk("amp_value", 5'h0b, 8'h87);
        // Distinct limits show that both offsets share the first one.
        for (i = 0; i < 4; i++)
            wr_reg(5'h0c + i[4:0], 8'h10 * (i[7:0] + 8'h01));
        for (i = 0; i < 5; i++)
        begin
            lim = (i < 2) ? 8'h10 : 8'h10 * i[7:0];
            res[i] <= lim + 8'h01;
            wt(5);
            rd_chk("res_over", 5'h00, 8'h80);
            res[i] <= ~lim + 8'h01;
            wt(5);
            rd_chk("res_at", 5'h00, 8'h00);
        end
        $display("test monitors ended");
        wr_reg(5'h05, 8'h18);
        for (i = 0; i < 2; i++)
        begin
            ev <= i[0] ? 2'b10 : 2'b01;
            @(posedge clk_sys);
            ev <= 2'b00;
            wt(2);
            out_chk(1'b0, 1'b1);
            rd_chk("event", 5'h07, {6'h00, ev_bits(i)});
            wr_reg(5'h07, {6'h00, ev_bits(i)});
            out_chk(1'b0, 1'b0);
        end
        wr_reg(5'h05, 8'h00);
        ev <= 2'b11;
        @(posedge clk_sys);
        ev <= 2'b00;
        wt(2);
        out_chk(1'b0, 1'b0);
        rd_chk("event_off", 5'h07, 8'h00);
        fatal <= 3'b100;
        @(posedge clk_sys);
        fatal <= 3'b000;
        wt(2);
        out_chk(1'b1, 1'b1);
        rd_chk("fatal", 5'h06, 8'h04);
        chk("status", 8'h05, status);
        wr_reg(5'h10, 8'h01);
        wt(2);
        out_chk(1'b0, 1'b0);
        rd_chk("fatal_clr", 5'h06, 8'h00);
        $display("test events ended");
        wr_reg(5'h10, 8'h21);
        wt(2);
        wr_reg(5'h10, 8'h23);
        wt(2);
        wr_reg(5'h10, 8'h11);
        wt(2);
        // The calibrate pin passes a synchroniser, so allow a short wait.
        cal_n <= 1'b0;
        hit = 1'b0;
        for (i = 0; i < 20 && !hit; i++)
        begin
            @(posedge clk_sys);
            #1;
            hit = ((cal_st & cal_all) === 1'b1);
        end
        cal_n <= 1'b1;
        chk("cal_pin", 8'h01, {7'h00, hit});
        if (!hit)
            final_report();
        $display("test commands ended");
        // Serial masks fully open; pin mode must override all three.
        wr_reg(5'h02, 8'hff);
        wr_reg(5'h03, 8'hff);
        wr_reg(5'h04, 8'hff);
        cond <= 8'h01;
        wt(4);
        out_chk(1'b1, 1'b1);
        pin_mode <= 1'b1;
        wt(10);
        out_chk(1'b0, 1'b0);
        chk("status_pin", 8'h02, status);
        cond <= 8'h04;
        wt(4);
        out_chk(1'b0, 1'b1);
        chk("led", 8'h01, {7'h00, led});
        cond <= 8'h00;
        sc <= 8'h3f;
        wt(30);
        out_chk(1'b0, 1'b1);
        sc <= 8'h40;
        wt(30);
        out_chk(1'b0, 1'b0);
        $display("test pin mode ended");
        final_report();
    end

    // Expected event pending pattern: rollover in bit 0, capture in bit 1.
    function automatic logic [1:0] ev_bits(input integer k);
        ev_bits = (k == 1) ? 2'b10 : 2'b01;
    endfunction
endmodule // tb

`default_nettype wire
